// *** include/ebt_pkg.sv ***
package ebt_pkg;

  // register byte offsets on the slave port
  localparam logic [7:0] EBT_CTRL_OFS   = 8'h00;
  localparam logic [7:0] EBT_TIMING_OFS = 8'h04;
  localparam logic [7:0] EBT_WDATA_OFS  = 8'h08;
  localparam logic [7:0] EBT_CMD_OFS    = 8'h0C;
  localparam logic [7:0] EBT_RDATA_OFS  = 8'h10;
  localparam logic [7:0] EBT_STATUS_OFS = 8'h14;

  // reset values
  localparam logic [31:0] EBT_CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] EBT_TIMING_RST = 32'h0000_0001;

  // control field positions
  localparam int EBT_CTRL_SHARED   = 0;
  localparam int EBT_CTRL_RDY_EN   = 1;
  localparam int EBT_CTRL_RDY_HIGH = 2;
  localparam int EBT_CTRL_RDY_ASYN = 3;
  localparam int EBT_CTRL_BUS_REFERENCE_CLOCK   = 4;

  // timing field positions
  localparam int EBT_TM_AB_LSB = 0;
  localparam int EBT_TM_C_LSB  = 4;
  localparam int EBT_TM_D_LSB  = 8;
  localparam int EBT_TM_E_LSB  = 12;
  localparam int EBT_TM_F_LSB  = 20;

  // phase length limits in phase time units
  localparam logic [5:0] EBT_AB_MIN = 6'h01;
  localparam logic [5:0] EBT_AB_MAX = 6'h05;
  localparam int EBT_FIFO_DEPTH     = 16;

  // one command word kept in the fifo
  typedef struct packed {
    logic        write;
    logic [23:0] addr;
    logic [15:0] data;
  } ebt_cmd_t;

  // external bus pin drive group
  typedef struct packed {
    logic [23:0] address_lines;
    logic [15:0] shared_ad_out;
    logic        shared_ad_oe;
    logic [15:0] data_out;
    logic        data_oe;
    logic        ale;
    logic        rd_n;
    logic        wr_n;
    logic        cs_n;
    logic        upper_byte_enable_n;
    logic        bus_reference_clock_src_sys;
    logic        bus_reference_clock_fast_drv;
  } ebt_pins_t;

  // bus cycle phases, one-hot
  typedef enum logic [5:0] {
    EBT_IDLE = 6'b000001,
    EBT_AB   = 6'b000010,
    EBT_C    = 6'b000100,
    EBT_D    = 6'b001000,
    EBT_E    = 6'b010000,
    EBT_F    = 6'b100000
  } ebt_phase_t;

endpackage

// *** src/ebt_fifo.sv ***
`timescale 1ns/1ps
module ebt_fifo #(
  parameter int WIDTH = 41,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,       // clock
  input  wire logic             rst_n,     // async reset, active low
  input  wire logic             in_valid,  // push request
  output logic                  in_ready,  // room for a word
  input  wire logic [WIDTH-1:0] in_data,   // pushed word
  output logic                  out_valid, // word available
  input  wire logic             out_ready, // pop request
  output logic [WIDTH-1:0]      out_data   // head word, registered
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];   // storage
  logic [AW-1:0]    wr_ptr;        // write index
  logic [AW-1:0]    rd_ptr;        // read index
  logic [AW:0]      count;         // words stored
  logic             do_push;       // accepted push
  logic             do_pop;        // accepted pop

  assign do_push = in_valid && in_ready;
  assign do_pop  = out_valid && out_ready;

  // storage writes; no reset so it maps to plain ram
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers, fill count and honest flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count     <= count + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
      in_ready  <= (count + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop})
                   != (AW+1)'(DEPTH);
      out_valid <= (count + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop})
                   != '0;
    end
  end

  // head word comes out of a register; write-through when pushing into empty
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_data <= '0;
    end else if (do_pop || !out_valid) begin
      if (do_push && (count - {{AW{1'b0}}, do_pop}) == '0) begin
        out_data <= in_data;
      end else begin
        out_data <= mem[do_pop ? rd_ptr + 1'b1 : rd_ptr];
      end
    end
  end
endmodule

// *** src/ebt_bus_timing.sv ***
`timescale 1ns/1ps
// Functional notes
// - cycle runs phases AB, C, D, E, F in order
// - phase lengths come from software timing register
// - ready may stretch access phase when enabled
// - lengths: AB 1-5, C 0-3, D 0-1, E 1-32, F 0-3
// - read data latched on address change, strobe rise
// - early address change cannot corrupt read data
// - shared mode: address then write data, 16 lines
// - separate mode: 24-bit address, 16-bit data lines
// - reference clock: system clock source, fast driver
// - ready polarity selectable; async adds one stage
// - ready inactive waits, ready active ends access phase
module ebt_bus_timing #(
  parameter int FIFO_DEPTH = ebt_pkg::EBT_FIFO_DEPTH
) (
  input  wire logic              hclk,          // system clock
  input  wire logic              hresetn,       // async reset, active low
  input  wire logic              hsel,          // slave select
  input  wire logic [31:0]       haddr,         // byte address
  input  wire logic [1:0]        htrans,        // transfer type
  input  wire logic              hwrite,        // write when high
  input  wire logic [2:0]        hsize,         // transfer size
  input  wire logic [31:0]       hwdata,        // write data
  input  wire logic              hready,        // bus ready in
  output logic                   hreadyout,     // slave ready out
  output logic                   hresp,         // always okay
  output logic [31:0]            hrdata,        // read data
  input  wire logic              ready_pin,     // external ready pin
  input  wire logic [15:0]       shared_ad_in,  // shared lines, in
  input  wire logic [15:0]       data_in,       // data lines, in
  output ebt_pkg::ebt_pins_t     pins           // all bus pin drives
);

  // ---------------- register file state ----------------
  logic [31:0] ctrl;          // mode, ready and clock controls
  logic [31:0] timing;        // chip_select_timing_config
  logic [15:0] wdata;         // write data for the next command
  logic [15:0] rdata;         // last captured read data
  logic [7:0]  done_count;    // completed bus cycles, wraps

  // ---------------- ahb pipeline ----------------
  logic        aph_take;      // address phase accepted
  logic        dph_wr;        // write data phase pending
  logic [7:0]  dph_ofs;       // offset of pending write
  logic        cmd_pend;      // command push waiting for room
  logic [23:0] cmd_addr;      // address of waiting command
  logic        cmd_write;     // direction of waiting command

  // ---------------- fifo ----------------
  ebt_pkg::ebt_cmd_t fifo_in;    // word being pushed
  ebt_pkg::ebt_cmd_t fifo_out;   // head word
  logic              fifo_in_rdy;  // room in fifo
  logic              fifo_out_vld; // head valid
  logic              fifo_pop;     // sequencer takes head

  // ---------------- sequencer ----------------
  ebt_pkg::ebt_phase_t phase;       // current phase
  ebt_pkg::ebt_phase_t next_phase;  // phase after this edge
  logic [5:0]  cnt;                 // units left in phase, minus one
  logic [5:0]  next_cnt;            // value loaded on entry
  ebt_pkg::ebt_cmd_t cur;           // command being run
  logic        phase_end;           // last unit of current phase
  logic        ready_ok;            // access phase may terminate

  // ---------------- ready synchroniser ----------------
  logic        rdy_s1;        // first stage, feeds rdy_s2 only
  logic        rdy_s2;        // second stage
  logic        rdy_s3;        // extra stage for async ready
  logic        rdy_active;    // polarity-corrected ready

  // ---------------- phase lengths ----------------
  logic [5:0]  len_ab;        // address phase length
  logic [5:0]  len_c;         // delay phase c length
  logic [5:0]  len_d;         // delay phase d length
  logic [5:0]  len_e;         // access phase length
  logic [5:0]  len_f;         // hold phase length
  logic [2:0]  ab_raw;        // programmed address phase field

  // field decode; out-of-range address phase values are clamped
  assign ab_raw = timing[ebt_pkg::EBT_TM_AB_LSB +: 3];
  always_comb begin
    len_ab = {3'h0, ab_raw};
    if (len_ab < ebt_pkg::EBT_AB_MIN) begin
      len_ab = ebt_pkg::EBT_AB_MIN;
    end else if (len_ab > ebt_pkg::EBT_AB_MAX) begin
      len_ab = ebt_pkg::EBT_AB_MAX;
    end
  end
  assign len_c = {4'h0, timing[ebt_pkg::EBT_TM_C_LSB +: 2]};
  assign len_d = {5'h00, timing[ebt_pkg::EBT_TM_D_LSB]};
  assign len_e = {1'b0, timing[ebt_pkg::EBT_TM_E_LSB +: 5]} + 6'h01;
  assign len_f = {4'h0, timing[ebt_pkg::EBT_TM_F_LSB +: 2]};

  // ---------------- ahb slave ----------------
  assign aph_take = hsel && htrans[1] && hready && hreadyout;
  assign hresp    = 1'b0;

  // address phase: latch write target, prepare read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_wr  <= 1'b0;
      dph_ofs <= 8'h00;
      hrdata  <= 32'h0000_0000;
    end else begin
      dph_wr <= aph_take && hwrite;
      if (aph_take) begin
        dph_ofs <= haddr[7:0];
        // reads answer in the data phase right after; unmapped reads zero
        unique case (haddr[7:0])
          ebt_pkg::EBT_CTRL_OFS:   hrdata <= ctrl;
          ebt_pkg::EBT_TIMING_OFS: hrdata <= timing;
          ebt_pkg::EBT_WDATA_OFS:  hrdata <= {16'h0000, wdata};
          ebt_pkg::EBT_RDATA_OFS:  hrdata <= {16'h0000, rdata};
          ebt_pkg::EBT_STATUS_OFS: hrdata <= {16'h0000, done_count, 5'h00,
                                              !fifo_in_rdy, !fifo_out_vld,
                                              phase != ebt_pkg::EBT_IDLE};
          default:                 hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // control registers written in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl   <= ebt_pkg::EBT_CTRL_RST;
      timing <= ebt_pkg::EBT_TIMING_RST;
      wdata  <= 16'h0000;
    end else if (dph_wr) begin
      unique case (dph_ofs)
        ebt_pkg::EBT_CTRL_OFS:   ctrl   <= {27'h0000000, hwdata[4:0]};
        ebt_pkg::EBT_TIMING_OFS: timing <= {10'h000, hwdata[21:20], 3'h0,
                                            hwdata[16:12], 3'h0, hwdata[8],
                                            2'h0, hwdata[5:4], 1'b0,
                                            hwdata[2:0]};
        ebt_pkg::EBT_WDATA_OFS:  wdata  <= hwdata[15:0];
        default: ;
      endcase
    end
  end

  // command writes push into the fifo; a full fifo stalls the bus
  // through hreadyout, so software cannot overrun the queue
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_pend  <= 1'b0;
      cmd_addr  <= 24'h000000;
      cmd_write <= 1'b0;
      hreadyout <= 1'b1;
    end else if (cmd_pend) begin
      if (fifo_in_rdy) begin
        cmd_pend  <= 1'b0;
        hreadyout <= 1'b1;
      end
    end else if (dph_wr && dph_ofs == ebt_pkg::EBT_CMD_OFS) begin
      cmd_addr  <= hwdata[23:0];
      cmd_write <= hwdata[31];
      cmd_pend  <= 1'b1;
      hreadyout <= 1'b0;
    end
  end

  // a command write holds the bus at least one cycle, until it lands in the fifo
  assign fifo_in = '{write: cmd_write, addr: cmd_addr, data: wdata};

  ebt_fifo #(
    .WIDTH ($bits(ebt_pkg::ebt_cmd_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (hclk),
    .rst_n     (hresetn),
    .in_valid  (cmd_pend),
    .in_ready  (fifo_in_rdy),
    .in_data   (fifo_in),
    .out_valid (fifo_out_vld),
    .out_ready (fifo_pop),
    .out_data  (fifo_out)
  );

  // ---------------- ready input ----------------
  // pin is asynchronous to hclk, so two flops come first in all modes;
  // the async option adds a third stage and thus a waitstate
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdy_s1 <= 1'b0;
      rdy_s2 <= 1'b0;
      rdy_s3 <= 1'b0;
    end else begin
      rdy_s1 <= ready_pin;
      rdy_s2 <= rdy_s1;
      rdy_s3 <= rdy_s2;
    end
  end

  // polarity select and stage select
  assign rdy_active = (ctrl[ebt_pkg::EBT_CTRL_RDY_ASYN] ? rdy_s3 : rdy_s2)
                      ^ !ctrl[ebt_pkg::EBT_CTRL_RDY_HIGH];

  // access phase may close only when handshake is off or ready seen
  assign ready_ok = !ctrl[ebt_pkg::EBT_CTRL_RDY_EN] || rdy_active;

  // ---------------- phase sequencer ----------------
  // a phase ends when its counter reaches zero; in the access phase
  // an inactive ready at that point inserts a waitstate instead
  assign phase_end = (cnt == 6'h00) &&
                     (phase != ebt_pkg::EBT_E || ready_ok);
  assign fifo_pop  = (phase == ebt_pkg::EBT_IDLE) && fifo_out_vld;

  // next phase skips zero-length optional phases
  always_comb begin
    next_phase = phase;
    unique case (phase)
      ebt_pkg::EBT_IDLE: begin
        if (fifo_out_vld) begin
          next_phase = ebt_pkg::EBT_AB;
        end
      end
      ebt_pkg::EBT_AB: begin
        if (phase_end) begin
          if (len_c != 6'h00) begin
            next_phase = ebt_pkg::EBT_C;
          end else if (len_d != 6'h00) begin
            next_phase = ebt_pkg::EBT_D;
          end else begin
            next_phase = ebt_pkg::EBT_E;
          end
        end
      end
      ebt_pkg::EBT_C: begin
        if (phase_end) begin
          next_phase = (len_d != 6'h00) ? ebt_pkg::EBT_D : ebt_pkg::EBT_E;
        end
      end
      ebt_pkg::EBT_D: begin
        if (phase_end) begin
          next_phase = ebt_pkg::EBT_E;
        end
      end
      ebt_pkg::EBT_E: begin
        if (phase_end) begin
          next_phase = (len_f != 6'h00) ? ebt_pkg::EBT_F : ebt_pkg::EBT_IDLE;
        end
      end
      ebt_pkg::EBT_F: begin
        if (phase_end) begin
          next_phase = ebt_pkg::EBT_IDLE;
        end
      end
      default: next_phase = ebt_pkg::EBT_IDLE;
    endcase
  end

  // counter reload on entry to a phase, one unit per clock
  always_comb begin
    next_cnt = 6'h00;
    unique case (next_phase)
      ebt_pkg::EBT_AB: next_cnt = len_ab - 6'h01;
      ebt_pkg::EBT_C:  next_cnt = len_c - 6'h01;
      ebt_pkg::EBT_D:  next_cnt = len_d - 6'h01;
      ebt_pkg::EBT_E:  next_cnt = len_e - 6'h01;
      ebt_pkg::EBT_F:  next_cnt = len_f - 6'h01;
      default:         next_cnt = 6'h00;
    endcase
  end

  // phase and counter; waitstates hold the counter at zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase <= ebt_pkg::EBT_IDLE;
      cnt   <= 6'h00;
    end else if (next_phase != phase) begin
      phase <= next_phase;
      cnt   <= next_cnt;
    end else if (cnt != 6'h00) begin
      cnt <= cnt - 6'h01;
    end
  end

  // command register for the running cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur <= '0;
    end else if (fifo_pop) begin
      cur <= fifo_out;
    end
  end

  // ---------------- read capture ----------------
  // the edge that leaves the access phase also raises the read strobe
  // and moves the address, so data are taken before either can matter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata      <= 16'h0000;
      done_count <= 8'h00;
    end else begin
      if (phase == ebt_pkg::EBT_E && phase_end && !cur.write) begin
        rdata <= ctrl[ebt_pkg::EBT_CTRL_SHARED] ? shared_ad_in
                                                : data_in;
      end
      if (phase != ebt_pkg::EBT_IDLE && next_phase == ebt_pkg::EBT_IDLE) begin
        done_count <= done_count + 8'h01;
      end
    end
  end

  // ---------------- pin drive ----------------
  // pins are registered from next_phase so they change on phase edges
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pins <= '{address_lines: 24'h000000, shared_ad_out: 16'h0000,
                shared_ad_oe: 1'b0, data_out: 16'h0000, data_oe: 1'b0,
                ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1, cs_n: 1'b1,
                upper_byte_enable_n: 1'b1, bus_reference_clock_src_sys: 1'b0,
                bus_reference_clock_fast_drv: 1'b0};
    end else begin
      // reference clock: system clock selected with the fast driver
      pins.bus_reference_clock_src_sys  <= ctrl[ebt_pkg::EBT_CTRL_BUS_REFERENCE_CLOCK];
      pins.bus_reference_clock_fast_drv <= ctrl[ebt_pkg::EBT_CTRL_BUS_REFERENCE_CLOCK];
      pins.cs_n  <= next_phase == ebt_pkg::EBT_IDLE;
      pins.upper_byte_enable_n <= next_phase == ebt_pkg::EBT_IDLE;
      pins.ale   <= next_phase == ebt_pkg::EBT_AB;
      pins.rd_n  <= !(next_phase == ebt_pkg::EBT_E && !cur_cmd_write());
      pins.wr_n  <= !(next_phase == ebt_pkg::EBT_E && cur_cmd_write());
      // address held to the end of the strobe; writes keep it through hold
      if (next_phase == ebt_pkg::EBT_IDLE ||
          (next_phase == ebt_pkg::EBT_F && !cur.write)) begin
        pins.address_lines <= 24'h000000;
      end else begin
        pins.address_lines <= cur_cmd_addr();
      end
      if (ctrl[ebt_pkg::EBT_CTRL_SHARED]) begin
        // shared lines: address in phase AB, then write data
        pins.data_oe  <= 1'b0;
        pins.data_out <= 16'h0000;
        if (next_phase == ebt_pkg::EBT_AB) begin
          pins.shared_ad_out <= 16'(cur_cmd_addr());
          pins.shared_ad_oe  <= 1'b1;
        end else if (next_phase != ebt_pkg::EBT_IDLE && cur.write) begin
          pins.shared_ad_out <= cur.data;
          pins.shared_ad_oe  <= 1'b1;
        end else begin
          pins.shared_ad_out <= 16'h0000;
          pins.shared_ad_oe  <= 1'b0;
        end
      end else begin
        // separate lines: write data on the data lines after AB
        pins.shared_ad_out <= 16'h0000;
        pins.shared_ad_oe  <= 1'b0;
        if (next_phase != ebt_pkg::EBT_IDLE &&
            next_phase != ebt_pkg::EBT_AB && cur.write) begin
          pins.data_out <= cur.data;
          pins.data_oe  <= 1'b1;
        end else begin
          pins.data_out <= 16'h0000;
          pins.data_oe  <= 1'b0;
        end
      end
    end
  end

  // command fields seen at the pins: in the entry cycle of AB the
  // running register is still loading, so the fifo head is used
  function automatic logic cur_cmd_write();
    return (phase == ebt_pkg::EBT_IDLE) ? fifo_out.write : cur.write;
  endfunction

  function automatic logic [23:0] cur_cmd_addr();
    return (phase == ebt_pkg::EBT_IDLE) ? fifo_out.addr : cur.addr;
  endfunction

endmodule

// *** tb/ebt_bus_timing_monitor.sv ***
`timescale 1ns/1ps
module ebt_bus_timing_monitor #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic               hclk,    // system clock
  input wire logic               hresetn, // async reset, active low
  input wire logic               hresp,   // bus response
  input wire ebt_pkg::ebt_pins_t pins     // bus pin drives
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // a cycle opens in the address phase
  sequence s_open;
    $fell(pins.cs_n) ##0 pins.ale;
  endsequence
  // any strobe low
  wire strobe = !pins.rd_n || !pins.wr_n;
  a_ab_first: assert property ($fell(pins.cs_n) |-> pins.ale)
    else $error("cycle did not open with address phase");
  a_ab_bound: assert property (s_open |-> ##[1:5] !pins.ale)
    else $error("address phase longer than five clocks");
  a_strobe_frame: assert property (strobe |-> !pins.cs_n && !pins.ale)
    else $error("strobe outside access phase");
  a_strobe_mutex: assert property (!(!pins.rd_n && !pins.wr_n))
    else $error("read and write strobes together");
  a_rd_addr_hold: assert property (!pins.rd_n && !$past(pins.rd_n) |-> $stable(pins.address_lines))
    else $error("address moved during read strobe");
  a_rd_end_addr: assert property ($rose(pins.rd_n) |-> pins.address_lines == 24'h000000)
    else $error("address not changed at read strobe end");
  a_rd_no_drive: assert property (!pins.rd_n |-> !pins.data_oe && !pins.shared_ad_oe)
    else $error("device drives data during read");
  a_wr_one_bus: assert property (!pins.wr_n |-> pins.data_oe != pins.shared_ad_oe)
    else $error("write data not on exactly one bus");
  a_ab_no_data: assert property (pins.ale |-> !pins.data_oe)
    else $error("data lines driven in address phase");
  a_ube_frame: assert property (pins.upper_byte_enable_n == pins.cs_n)
    else $error("upper byte enable not framed with chip select");
  a_clk_pair: assert property (pins.bus_reference_clock_src_sys == pins.bus_reference_clock_fast_drv)
    else $error("reference clock controls disagree");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
endmodule
bind ebt_bus_timing ebt_bus_timing_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) u_mon (
  .hclk(hclk), .hresetn(hresetn), .hresp(hresp), .pins(pins));

// *** tb/ebt_ext_partner.sv ***
`timescale 1ns/1ps
module ebt_ext_partner (
  input  wire logic               hclk,         // system clock
  input  wire ebt_pkg::ebt_pins_t pins,         // device pin drives
  input  wire logic [5:0]         wait_n,       // strobe clocks before ready
  input  wire logic               rdy_pol,      // 1 when ready is active high
  output logic                    ready_pin,    // ready back to device
  output logic [15:0]             shared_ad_in, // shared lines toward device
  output logic [15:0]             data_in       // data lines toward device
);
  logic [15:0] mem [16]; // small word store, low address bits only
  logic [3:0]  lat;      // latched address
  logic        mux;      // cycle ran on shared lines
  logic [5:0]  cnt;      // strobe low clocks so far
  logic [15:0] last;     // last driven word, inverted when released
  wire strobe = !pins.rd_n || !pins.wr_n;
  wire act    = strobe && (cnt >= wait_n);
  // ready drops with the strobe so the next cycle starts unready
  assign ready_pin    = act ~^ rdy_pol;
  // released lines show the inverse so a late capture is caught
  assign data_in      = (!pins.rd_n && !mux) ? mem[lat] : ~last;
  assign shared_ad_in = (!pins.rd_n && mux) ? mem[lat] : ~last;
  initial begin
    lat  = 4'h0;
    mux  = 1'b0;
    cnt  = 6'h00;
    last = 16'h0000;
  end
  // address latch, write capture, strobe counter
  always @(posedge hclk) begin
    if (pins.ale) begin
      lat <= pins.shared_ad_oe ? pins.shared_ad_out[3:0] : pins.address_lines[3:0];
      mux <= pins.shared_ad_oe;
    end
    if (!pins.wr_n) mem[lat] <= mux ? pins.shared_ad_out : pins.data_out;
    cnt  <= strobe ? cnt + 6'h01 : 6'h00;
    last <= pins.rd_n ? last : mem[lat];
  end
endmodule

// *** tb/test_external_bus_cycle_timing.sv ***
`timescale 1ns/1ps
module test_external_bus_cycle_timing;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, ready_pin, rdy_pol;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, r, l4, l8s;
  logic [15:0] shared_ad_in, data_in;
  logic [5:0]  wait_n;
  ebt_pkg::ebt_pins_t pins;
  int mismatches, comparisons, cycles, cs_cnt, st_cnt, last_cs, last_st, ncmd, ab;
  // phase table: raw address length clamps into 1..5
  logic [2:0] t_ab [4] = '{3'h0, 3'h2, 3'h5, 3'h7};
  logic [1:0] t_c [4]  = '{2'h0, 2'h3, 2'h1, 2'h2};
  logic [1:0] t_f [4]  = '{2'h0, 2'h3, 2'h2, 2'h1};
  logic [5:0] t_e [4]  = '{6'h01, 6'h20, 6'h04, 6'h02};
  logic       t_d [4]  = '{1'b0, 1'b1, 1'b0, 1'b1};
  logic [3:0] rmode [3] = '{4'h6, 4'hE, 4'h2};
  ebt_bus_timing #(.FIFO_DEPTH(16)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ready_pin(ready_pin),
    .shared_ad_in(shared_ad_in), .data_in(data_in), .pins(pins));
  ebt_ext_partner u_mem (
    .hclk(hclk), .pins(pins), .wait_n(wait_n), .rdy_pol(rdy_pol), .ready_pin(ready_pin),
    .shared_ad_in(shared_ad_in), .data_in(data_in));
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  task stop_test;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one single transfer; address held until ready, then data phase
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h000000, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
  task rd(input logic [7:0] a);
    ahb(1'b0, a, 32'h00000000);
  endtask
  // poll until no phase runs and the fifo is empty
  task wait_idle;
    r = 32'h00000000;
    while (r[2:0] !== 3'b010) rd(ebt_pkg::EBT_STATUS_OFS);
    repeat (2) @(posedge hclk);
  endtask
  task ext_cycle(input logic w, input logic [23:0] a);
    ahb(1'b1, ebt_pkg::EBT_CMD_OFS, {w, 7'h00, a});
    ncmd++;
    wait_idle;
  endtask
  // frame and strobe lengths seen on the pins, plus the hang limit
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (!pins.cs_n) cs_cnt <= cs_cnt + 1;
    else if (cs_cnt != 0) begin
      last_cs <= cs_cnt;
      cs_cnt  <= 0;
    end
    if (!pins.rd_n || !pins.wr_n) st_cnt <= st_cnt + 1;
    else if (st_cnt != 0) begin
      last_st <= st_cnt;
      st_cnt  <= 0;
    end
    if (cycles == 20000) begin
      mismatches++;
      stop_test;
    end
  end
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, rdy_pol, wait_n} = '0;
    {mismatches, comparisons, cycles, cs_cnt, st_cnt, last_cs, last_st, ncmd} = '0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(ebt_pkg::EBT_CTRL_OFS);   check(r, ebt_pkg::EBT_CTRL_RST);
    rd(ebt_pkg::EBT_TIMING_OFS); check(r, ebt_pkg::EBT_TIMING_RST);
    rd(ebt_pkg::EBT_STATUS_OFS); check(r, 32'h00000002);
    rd(8'h20);                   check(r, 32'h00000000);
    ahb(1'b1, ebt_pkg::EBT_RDATA_OFS, 32'h0000FFFF);
    rd(ebt_pkg::EBT_RDATA_OFS);  check(r, 32'h00000000);
    // write then read back in separate and shared modes
    for (int m = 0; m < 2; m++) begin
      ahb(1'b1, ebt_pkg::EBT_CTRL_OFS, 32'(m));
      ahb(1'b1, ebt_pkg::EBT_WDATA_OFS, 32'h0000A5C3 ^ 32'(m));
      ext_cycle(1'b1, 24'h000015 + 24'(m));
      ext_cycle(1'b0, 24'h000015 + 24'(m));
      rd(ebt_pkg::EBT_RDATA_OFS); check(r, 32'h0000A5C3 ^ 32'(m));
    end
    ahb(1'b1, ebt_pkg::EBT_CTRL_OFS, 32'h00000000);
    // each programmed length shows as clocks on the pins
    for (int i = 0; i < 4; i++) begin
      ab = (t_ab[i] == 3'h0) ? 1 : (t_ab[i] > 3'h5) ? 5 : int'(t_ab[i]);
      ahb(1'b1, ebt_pkg::EBT_TIMING_OFS, 32'(t_ab[i]) | (32'(t_c[i]) << 4)
          | (32'(t_d[i]) << 8) | (32'(t_e[i] - 6'h01) << 12) | (32'(t_f[i]) << 20));
      ext_cycle(1'b0, 24'h000015);
      check(32'(last_cs), 32'(ab + t_c[i] + t_d[i] + t_e[i] + t_f[i]));
      check(32'(last_st), 32'(t_e[i]));
    end
    ahb(1'b1, ebt_pkg::EBT_TIMING_OFS, ebt_pkg::EBT_TIMING_RST);
    // late ready stretches the strobe clock for clock
    for (int k = 0; k < 3; k++) begin
      ahb(1'b1, ebt_pkg::EBT_CTRL_OFS, 32'(rmode[k]));
      rdy_pol <= rmode[k][2];
      wait_n  <= 6'h04;
      ext_cycle(1'b0, 24'h000015);
      l4 = 32'(last_st);
      wait_n <= 6'h08;
      ext_cycle(1'b0, 24'h000015);
      check(32'(last_st) - l4, 32'h00000004);
      if (k == 0) l8s = 32'(last_st);
      if (k == 1) check(32'(last_st) - l8s, 32'h00000001);
    end
    wait_n <= 6'h00;
    // long access phases make the fifo fill and stall the bus
    ahb(1'b1, ebt_pkg::EBT_CTRL_OFS, 32'h00000000);
    ahb(1'b1, ebt_pkg::EBT_TIMING_OFS, 32'h0001F001);
    for (int j = 0; j < 18; j++) begin
      ahb(1'b1, ebt_pkg::EBT_CMD_OFS, 32'h00000015);
      ncmd++;
    end
    rd(ebt_pkg::EBT_STATUS_OFS); check({29'h0, r[2:0]}, 32'h00000005);
    wait_idle;
    rd(ebt_pkg::EBT_STATUS_OFS); check({24'h0, r[15:8]}, 32'(ncmd));
    rd(ebt_pkg::EBT_CMD_OFS);    check(r, 32'h00000000);
    ahb(1'b1, ebt_pkg::EBT_CTRL_OFS, 32'h00000010);
    repeat (2) @(posedge hclk);
    check({31'h0, pins.bus_reference_clock_src_sys & pins.bus_reference_clock_fast_drv}, 32'h00000001);
    stop_test;
  end
endmodule
